//--- hdl/acs_pkg.sv
// Constants for the converter sequencer: register map, fields, timing
`default_nettype none
package acs_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [4:0] IDX_CONTROL   = 5'h00;
	localparam logic [4:0] IDX_WINMODE   = 5'h04;
	localparam logic [4:0] IDX_SAMPLE_LENGTH   = 5'h05;
	localparam logic [4:0] IDX_POSSEL    = 5'h08;
	localparam logic [4:0] IDX_NEGSEL    = 5'h09;
	localparam logic [4:0] IDX_COMMAND   = 5'h0a;
	localparam logic [4:0] IDX_EVENT_TRIGGER_CONTROL    = 5'h0b;
	localparam logic [4:0] IDX_FLAGS     = 5'h0d;
	localparam logic [4:0] IDX_RESULT    = 5'h10;
	localparam logic [4:0] IDX_WINLOW    = 5'h12;
	localparam logic [4:0] IDX_WINHIGH   = 5'h14;
	// Field positions
	localparam int BIT_ENABLE    = 0;
	localparam int BIT_FREERUN   = 1;
	localparam int BIT_START     = 0;
	localparam int BIT_STOP      = 1;
	localparam int BIT_EVSTART   = 0;
	localparam int BIT_RESRDY    = 0;
	localparam int BIT_WINMATCH  = 1;
	// Reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	// Window modes
	localparam logic [2:0] WM_NONE    = 3'h0;
	localparam logic [2:0] WM_BELOW   = 3'h1;
	localparam logic [2:0] WM_ABOVE   = 3'h2;
	localparam logic [2:0] WM_INSIDE  = 3'h3;
	localparam logic [2:0] WM_OUTSIDE = 3'h4;
	// Input select codes
	localparam logic [6:0] SEL_POS_PIN_MAX = 7'h15;
	localparam logic [6:0] SEL_NEG_PIN_MAX = 7'h0f;
	localparam logic [6:0] SEL_GND         = 7'h40;
	localparam logic [6:0] SEL_TEMP        = 7'h42;
	localparam logic [6:0] SEL_DAC         = 7'h48;
	localparam logic [6:0] SEL_DACREF_LAST = 7'h4b;
	// Timing
	localparam int          SAMPLE_BASE_CYC = 2;
	localparam int          CONV_DIV_DEF    = 2;
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acs_state_t;
endpackage
`default_nettype wire

//--- hdl/acs_sequencer.sv
// Converter sequencer: APB registers, sample timing, input select, window
//
// Register access over APB is this design's own decision.
`default_nettype none
module acs_sequencer import acs_pkg::*; #(
	parameter int CONV_DIV = CONV_DIV_DEF
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Event trigger from outside
	input  wire logic        start_event,
	// Converter core
	input  wire logic        core_done,
	input  wire logic [15:0] core_result,
	output logic             core_go,
	output logic             sample_on,
	output logic             conv_tick,
	// Analog front end
	output logic      [6:0]  pos_input,
	output logic      [6:0]  neg_input,
	output logic             pos_legal,
	output logic             neg_legal
);
	if (CONV_DIV < 1 || CONV_DIV > 256) begin : g_div_check
		$error("CONV_DIV out of range");
	end

	function automatic logic pos_ok(input logic [6:0] c);
		pos_ok = (c <= SEL_POS_PIN_MAX) || c == SEL_GND || c == SEL_TEMP
			|| (c >= SEL_DAC && c <= SEL_DACREF_LAST);
	endfunction

	function automatic logic neg_ok(input logic [6:0] c);
		neg_ok = (c <= SEL_NEG_PIN_MAX) || c == SEL_GND || c == SEL_DAC;
	endfunction

	function automatic logic win_hit(input logic [2:0]  m,
					input logic [15:0] r,
					input logic [15:0] lo,
					input logic [15:0] hi);
		case (m)
			WM_BELOW:   win_hit = r < lo;
			WM_ABOVE:   win_hit = r > hi;
			WM_INSIDE:  win_hit = r >= lo && r <= hi;
			WM_OUTSIDE: win_hit = r < lo || r > hi;
			default:    win_hit = 1'b0;
		endcase
	endfunction

	logic [1:0]  rst_sync_r;
	logic        rst_n;
	logic [1:0]  ev_sync_r;
	logic        ev_prev_r;
	logic [7:0]  div_r;
	logic        tick_r;
	logic        enable_r;
	logic        freerun_r;
	logic [2:0]  winmode_r;
	logic [7:0]  sample_length_r;
	logic [6:0]  pos_reg_r;
	logic [6:0]  neg_reg_r;
	logic        evstart_r;
	logic        pend_r;
	logic        resrdy_r;
	logic        winflag_r;
	logic [15:0] result_r;
	logic [15:0] winlow_r;
	logic [15:0] winhigh_r;
	logic [8:0]  samp_cnt_r;
	acs_state_t  state_r;
	logic [31:0] rdata_nxt;
	logic        map_hit;
	logic [4:0]  idx;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        start_wr;
	logic        stop_wr;
	logic        ev_rise;
	logic        launch;
	logic        fin;

	assign rst_n = rst_sync_r[1];
	assign idx   = paddr[6:2];
	assign acc   = psel && penable && pready && map_hit && paddr[7] == 1'b0;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;
	assign stop_wr  = wr && idx == IDX_COMMAND && pwdata[BIT_STOP];
	assign start_wr = wr && idx == IDX_COMMAND && pwdata[BIT_START]
		&& !pwdata[BIT_STOP];
	assign ev_rise = evstart_r && ev_sync_r[1] && !ev_prev_r;
	assign fin     = state_r == ST_CONVERT && core_done;
	assign launch  = state_r == ST_IDLE && enable_r && !stop_wr
		&& (pend_r || start_wr || ev_rise);

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_sync_r <= 2'b00;
			ev_prev_r <= 1'b0;
		end else begin
			ev_sync_r <= {ev_sync_r[0], start_event};
			ev_prev_r <= ev_sync_r[1];
		end
	end

	// Converter clock enable
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r  <= 8'h00;
			tick_r <= 1'b0;
		end else if (div_r == 8'(CONV_DIV - 1)) begin
			div_r  <= 8'h00;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 8'h01;
			tick_r <= 1'b0;
		end
	end

	// APB answer one cycle after the access phase opens
	always_comb begin
		map_hit   = 1'b1;
		rdata_nxt = 32'h0000_0000;
		case (idx)
			IDX_CONTROL: rdata_nxt[1:0] = {freerun_r, enable_r};
			IDX_WINMODE: rdata_nxt[2:0] = winmode_r;
			IDX_SAMPLE_LENGTH: rdata_nxt[7:0] = sample_length_r;
			IDX_POSSEL:  rdata_nxt[6:0] = pos_reg_r;
			IDX_NEGSEL:  rdata_nxt[6:0] = neg_reg_r;
			IDX_COMMAND: rdata_nxt[BIT_START] = pend_r
				|| state_r != ST_IDLE;
			IDX_EVENT_TRIGGER_CONTROL:  rdata_nxt[BIT_EVSTART] = evstart_r;
			IDX_FLAGS:   rdata_nxt[1:0] = {winflag_r, resrdy_r};
			IDX_RESULT:  rdata_nxt[15:0] = result_r;
			IDX_WINLOW:  rdata_nxt[15:0] = winlow_r;
			IDX_WINHIGH: rdata_nxt[15:0] = winhigh_r;
			default:     map_hit = 1'b0;
		endcase
		if (paddr[7])
			map_hit = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !map_hit;
			if (psel && penable && !pready && !pwrite)
				prdata <= map_hit ? rdata_nxt : 32'h0000_0000;
		end
	end

	// Software-written settings
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_r  <= 1'b0;
			freerun_r <= 1'b0;
			winmode_r <= WM_NONE;
			sample_length_r <= RST_BYTE;
			pos_reg_r <= RST_BYTE[6:0];
			neg_reg_r <= RST_BYTE[6:0];
			evstart_r <= 1'b0;
			winlow_r  <= RST_WORD;
			winhigh_r <= RST_WORD;
		end else if (wr) begin
			case (idx)
				IDX_CONTROL: begin
					enable_r  <= pwdata[BIT_ENABLE];
					freerun_r <= pwdata[BIT_FREERUN];
				end
				IDX_WINMODE: winmode_r <= pwdata[2:0];
				IDX_SAMPLE_LENGTH: sample_length_r <= pwdata[7:0];
				IDX_POSSEL:  pos_reg_r <= pwdata[6:0];
				IDX_NEGSEL:  neg_reg_r <= pwdata[6:0];
				IDX_EVENT_TRIGGER_CONTROL:  evstart_r <= pwdata[BIT_EVSTART];
				IDX_WINLOW:  winlow_r  <= pwdata[15:0];
				IDX_WINHIGH: winhigh_r <= pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// Start pending until the sequencer is back in idle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pend_r <= 1'b0;
		else if (stop_wr || !enable_r)
			pend_r <= 1'b0;
		else if (start_wr && state_r != ST_IDLE)
			pend_r <= 1'b1;
		else if (launch)
			pend_r <= 1'b0;
	end

	// Sequence: sample, then wait for the core
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ST_IDLE;
			samp_cnt_r <= 9'h000;
			core_go    <= 1'b0;
		end else begin
			core_go <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (launch) begin
						state_r    <= ST_SAMPLE;
						samp_cnt_r <= 9'(SAMPLE_BASE_CYC)
							+ {1'b0, sample_length_r};
					end
				end
				ST_SAMPLE: begin
					if (stop_wr || !enable_r)
						state_r <= ST_IDLE;
					else if (tick_r && samp_cnt_r == 9'h001) begin
						state_r <= ST_CONVERT;
						core_go <= 1'b1;
					end else if (tick_r)
						samp_cnt_r <= samp_cnt_r - 9'h001;
				end
				ST_CONVERT: begin
					if (stop_wr || !enable_r)
						state_r <= ST_IDLE;
					else if (core_done) begin
						if (freerun_r) begin
							state_r    <= ST_SAMPLE;
							samp_cnt_r <= 9'(SAMPLE_BASE_CYC)
								+ {1'b0, sample_length_r};
						end else
							state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Result capture and flags; set wins over clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_r  <= RST_WORD;
			resrdy_r  <= 1'b0;
			winflag_r <= 1'b0;
		end else begin
			if (fin)
				result_r <= core_result;
			if (fin)
				resrdy_r <= 1'b1;
			else if ((wr && idx == IDX_FLAGS && pwdata[BIT_RESRDY])
				|| (rd && idx == IDX_RESULT))
				resrdy_r <= 1'b0;
			if (fin && win_hit(winmode_r, core_result,
				winlow_r, winhigh_r))
				winflag_r <= 1'b1;
			else if ((wr && idx == IDX_FLAGS && pwdata[BIT_WINMATCH])
				|| (rd && idx == IDX_RESULT))
				winflag_r <= 1'b0;
		end
	end

	// Front-end selection follows registers only between conversions
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_input <= RST_BYTE[6:0];
			neg_input <= RST_BYTE[6:0];
			// Reset code zero selects pin 0, a legal input
			pos_legal <= 1'b1;
			neg_legal <= 1'b1;
		end else if (state_r == ST_IDLE || fin) begin
			pos_input <= pos_reg_r;
			neg_input <= neg_reg_r;
			pos_legal <= pos_ok(pos_reg_r);
			neg_legal <= neg_ok(neg_reg_r);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_on <= 1'b0;
			conv_tick <= 1'b0;
		end else begin
			sample_on <= state_r == ST_SAMPLE;
			conv_tick <= tick_r;
		end
	end
endmodule
`default_nettype wire

//--- testbench/acs_sequencer_props.sv
// Port checker for the converter sequencer
`default_nettype none
module acs_sequencer_props import acs_pkg::*; #(
	parameter int CONV_DIV = CONV_DIV_DEF
) (
	input wire logic       ref_clk,
	input wire logic       rstn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       core_go,
	input wire logic       sample_on,
	input wire logic       conv_tick,
	input wire logic [6:0] pos_input,
	input wire logic [6:0] neg_input,
	input wire logic       pos_legal,
	input wire logic       neg_legal
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
		else $error("pready without access phase");
	AST_PSLVERR_QUAL: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_GO_PULSE: assert property (core_go |=> !core_go)
		else $error("core_go longer than one cycle");
	AST_TICK_PULSE: assert property (conv_tick && CONV_DIV > 1 |=> !conv_tick)
		else $error("conv_tick not a pulse");
	AST_POS_LEGAL: assert property (pos_legal == (pos_input <= SEL_POS_PIN_MAX
		|| pos_input == SEL_GND || pos_input == SEL_TEMP
		|| (pos_input >= SEL_DAC && pos_input <= SEL_DACREF_LAST)))
		else $error("positive legal flag wrong");
	AST_NEG_LEGAL: assert property (neg_legal == (neg_input <= SEL_NEG_PIN_MAX
		|| neg_input == SEL_GND || neg_input == SEL_DAC))
		else $error("negative legal flag wrong");
	AST_SEL_HOLD: assert property (sample_on && $past(sample_on) |->
		$stable(pos_input) && $stable(neg_input))
		else $error("input select moved while sampling");
	cover property (core_go);
	cover property (pready && pslverr);
	cover property ($fell(sample_on));
endmodule
bind acs_sequencer acs_sequencer_props #(.CONV_DIV(CONV_DIV)) u_props (
	.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .core_go(core_go),
	.sample_on(sample_on), .conv_tick(conv_tick), .pos_input(pos_input),
	.neg_input(neg_input), .pos_legal(pos_legal), .neg_legal(neg_legal));
`default_nettype wire

//--- testbench/acs_front_model.sv
// Behavioural converter core: answers each sampling end after a delay
`default_nettype none
module acs_front_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        core_go,
	input  wire logic [15:0] value,
	input  wire logic [7:0]  delay,
	output logic             core_done,
	output logic      [15:0] core_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] cnt_r;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r       <= 9'h000;
			core_done   <= 1'b0;
			core_result <= 16'h0000;
		end else begin
			core_done <= 1'b0;
			if (core_go) begin
				cnt_r <= {1'b0, delay} + 9'h001;
			end else if (cnt_r == 9'h001) begin
				cnt_r       <= 9'h000;
				core_done   <= 1'b1;
				core_result <= value;
			end else begin
				// Result is junk outside the done pulse
				core_result <= ~core_result;
				if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb_adc_conversion_sequencer.sv
// Self-checking bench for the converter sequencer
`default_nettype none
module tb_adc_conversion_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	import acs_pkg::*;
	logic        ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00, dly = 8'h03;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, start_event = 0, core_done, core_go;
	logic        sample_on, conv_tick, pos_legal, neg_legal;
	logic [15:0] core_result, value = 16'h0000;
	logic [6:0]  pos_input, neg_input;
	int          err_total = 0, checks_done = 0, go_cnt = 0, tk = 0, ticks = 0;
	always #5 ref_clk = ~ref_clk;
	acs_sequencer #(.CONV_DIV(2)) dut (.ref_clk(ref_clk), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.start_event(start_event), .core_done(core_done),
		.core_result(core_result), .core_go(core_go), .sample_on(sample_on),
		.conv_tick(conv_tick), .pos_input(pos_input), .neg_input(neg_input),
		.pos_legal(pos_legal), .neg_legal(neg_legal));
	acs_front_model u_front (.ref_clk(ref_clk), .rstn(rstn),
		.core_go(core_go), .value(value), .delay(dly),
		.core_done(core_done), .core_result(core_result));
	// Converter ticks seen while sampling; ticks holds the last count
	always @(posedge ref_clk) begin
		if (core_go) go_cnt <= go_cnt + 1;
		if (!sample_on) tk <= 0;
		else if (conv_tick) tk <= tk + 1;
		if (sample_on) ticks <= tk + (conv_tick ? 1 : 0);
	end
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string m);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [4:0] i, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {1'b0, i, 2'b00};
		pwdata <= d;
		@(posedge ref_clk) penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 20);
		q = prdata;
		chk(pslverr, i == 5'h0f, "pslverr");
		if (n >= 20) begin chk(0, 1, "apb hang"); conclude(); end
		psel <= 0; penable <= 0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [4:0] i, input logic [31:0] e);
		apb(0, i, 0);
		chk(q, e, "read");
	endtask
	task automatic wait_hi(input bit go);
		int n;
		n = 0;
		do @(posedge ref_clk); while ((go ? core_go : core_done) !== 1 && ++n < 600);
		if (n >= 600) begin chk(0, 1, "wait hang"); conclude(); end
	endtask
	task automatic t_regs();
		logic [4:0] r[6] = '{IDX_WINMODE, IDX_SAMPLE_LENGTH, IDX_POSSEL, IDX_NEGSEL,
			IDX_COMMAND, IDX_EVENT_TRIGGER_CONTROL};
		foreach (r[k]) rd(r[k], 0);
		apb(0, 5'h0f, 0);
		$display("test regs done");
	endtask
	task automatic t_select();
		logic [6:0] c[10] = '{7'h15, 7'h16, 7'h40, 7'h41, 7'h42, 7'h48, 7'h4b,
			7'h4c, 7'h0f, 7'h10};
		foreach (c[k]) begin
			apb(1, IDX_POSSEL, c[k]);
			apb(1, IDX_NEGSEL, c[k]);
			@(posedge ref_clk);
			chk(pos_input, c[k], "pos");
			chk(neg_input, c[k], "neg");
			chk(pos_legal, c[k] <= 7'h15 || c[k] inside {7'h40, 7'h42}
				|| (c[k] >= 7'h48 && c[k] <= 7'h4b), "pos legal");
			chk(neg_legal, c[k] <= 7'h0f || c[k] inside {7'h40, 7'h48},
				"neg legal");
		end
		$display("test select done");
	endtask
	task automatic t_window();
		logic [15:0] v[4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
		logic m;
		apb(1, IDX_WINLOW, 32'h100);
		apb(1, IDX_WINHIGH, 32'h200);
		for (int w = 0; w < 8; w++) foreach (v[k]) begin
			m = w == 1 ? v[k] < 16'h100 : w == 2 ? v[k] > 16'h200 :
				w == 3 ? v[k] >= 16'h100 && v[k] <= 16'h200 :
				w == 4 ? v[k] < 16'h100 || v[k] > 16'h200 : 1'b0;
			apb(1, IDX_WINMODE, w);
			value <= v[k];
			apb(1, IDX_COMMAND, 1);
			wait_hi(0);
			repeat (2) @(posedge ref_clk);
			rd(IDX_FLAGS, {m, 1'b1});
			rd(IDX_RESULT, v[k]);
			rd(IDX_FLAGS, 0);
		end
		$display("test window done");
	endtask
	task automatic t_sample();
		int g;
		g = go_cnt;
		dly <= 8'h14;
		apb(1, IDX_SAMPLE_LENGTH, 5);
		apb(1, IDX_POSSEL, 5);
		apb(1, IDX_COMMAND, 1);
		apb(1, IDX_POSSEL, 7'h48);
		chk(pos_input, 5, "pos held");
		rd(IDX_COMMAND, 1);
		wait_hi(1);
		@(posedge ref_clk);
		chk(ticks, SAMPLE_BASE_CYC + 5, "sample ticks");
		apb(1, IDX_COMMAND, 1);
		wait_hi(0);
		repeat (2) @(posedge ref_clk);
		chk(pos_input, 7'h48, "pos after");
		wait_hi(0);
		repeat (2) @(posedge ref_clk);
		rd(IDX_COMMAND, 0);
		chk(go_cnt - g, 2, "pending start");
		$display("test sample done");
	endtask
	task automatic t_stop();
		int g;
		apb(1, IDX_SAMPLE_LENGTH, 20);
		g = go_cnt;
		apb(1, IDX_COMMAND, 1);
		apb(1, IDX_COMMAND, 2);
		apb(1, IDX_COMMAND, 3);
		apb(1, IDX_COMMAND, 0);
		repeat (90) @(posedge ref_clk);
		chk(go_cnt - g, 0, "stop");
		rd(IDX_COMMAND, 0);
		$display("test stop done");
	endtask
	task automatic t_free();
		int g;
		dly <= 8'h02;
		apb(1, IDX_SAMPLE_LENGTH, 0);
		apb(1, IDX_CONTROL, 3);
		g = go_cnt;
		apb(1, IDX_COMMAND, 1);
		repeat (200) @(posedge ref_clk);
		chk(go_cnt - g > 3, 1, "free run");
		apb(1, IDX_COMMAND, 2);
		apb(1, IDX_CONTROL, 1);
		g = go_cnt;
		repeat (60) @(posedge ref_clk);
		chk(go_cnt - g, 0, "free stop");
		$display("test free done");
	endtask
	task automatic t_event();
		int g;
		for (int e = 0; e < 2; e++) begin
			apb(1, IDX_EVENT_TRIGGER_CONTROL, e);
			g = go_cnt;
			start_event <= 1;
			repeat (60) @(posedge ref_clk);
			start_event <= 0;
			repeat (10) @(posedge ref_clk);
			chk(go_cnt - g, e, "event");
		end
		$display("test event done");
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rstn <= 1;
		repeat (4) @(posedge ref_clk);
		t_regs();
		t_select();
		apb(1, IDX_CONTROL, 1);
		t_window();
		t_sample();
		t_stop();
		t_free();
		t_event();
		conclude();
	end
endmodule
`default_nettype wire
